// *** logic/lpr_top.sv ***
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// Functional notes
// - One bit per segment; one means on
// - Register x: common x/4, segment base 16(x%4)
// - Reference enable bit powers internal reference
// - Contrast code sets ladder resistance code/7
// - Pin enables route bias levels externally
// - Interval A power field encodings
// - Interval B power field encodings
// - Type A: N clocks A, 16-N B
// - Type B: N clocks A, 32-N B
// - Code zero holds interval B always (the interval output resets to A and holds it until the first enabled clock)
// - Bits 14 and 3 read zero
// - Waveform bit selects type B when set
// - Disallowed data write sets sticky failure flag
module lpr_top #(
   parameter int NSEG = 64,
   parameter int NCOM = 8
) (
   // Clock, reset and clock enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // Register port.
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Timing controller status inputs, same clock domain.
   input wire logic data_write_allowed,
   input wire logic waveform_type_select,
   input wire logic lcd_tick,
   // Pixel drive and common select toward the glass driver.
   input wire logic [2:0] common_select,
   output logic [NSEG-1:0] segment_common_pixel_bit,
   // Bias generator controls and the write failure flag.
   output lpr_pkg::lpr_analog_t analog_ctrl,
   output logic data_write_failed_flag
);

   logic [15:0] pixel_on_data_x [lpr_pkg::NUM_DATA_REGS];
   logic [15:0] ladder_q;
   logic wfail_q;
   logic wfail_d;
   logic [4:0] sched_cnt_q;
   logic [4:0] sched_cnt_d;
   logic [4:0] period_last;
   logic period_end;
   logic [2:0] a_len;
   logic in_a;
   logic data_hit;
   logic pixel_we;
   logic ladder_we;
   logic write_refused;
   logic status_clear;
   logic [15:0] status_word;
   logic [15:0] rdata_d;
   logic [NSEG-1:0] row_d;
   logic ref_enable_d;
   logic [2:0] contrast_d;
   logic [2:0] pin_enable_d;
   lpr_pkg::lpr_pwr_t power_a;
   lpr_pkg::lpr_pwr_t power_b;
   lpr_pkg::lpr_pwr_t power_d;
   lpr_pkg::lpr_ivl_t interval_d;
   logic ref_enable_q;
   logic [2:0] contrast_q;
   logic [2:0] pin_enable_q;
   lpr_pkg::lpr_pwr_t power_q;
   lpr_pkg::lpr_ivl_t interval_q;

   // Address decode; every word below the ladder word is pixel memory.
   assign data_hit = (reg_addr < lpr_pkg::ADDR_LADDER);
   // A pixel write lands only while the timing controller allows it.
   assign pixel_we = reg_wr && data_hit && data_write_allowed;
   // Ladder word write strobe.
   assign ladder_we = reg_wr && (reg_addr == lpr_pkg::ADDR_LADDER);
   // A pixel write while writes are forbidden is refused and remembered.
   assign write_refused = reg_wr && data_hit && !data_write_allowed;
   // Software clears the failure flag by writing zero to its bit of the status word.
   assign status_clear = reg_wr && (reg_addr == lpr_pkg::ADDR_STATUS) && !reg_wdata[lpr_pkg::WFAIL_BIT];

   // Ladder fields, unpacked once so the output logic reads them by name.
   assign a_len = ladder_q[lpr_pkg::ALEN_LSB +: 3];
   assign ref_enable_d = ladder_q[lpr_pkg::IRE_BIT];
   assign contrast_d = ladder_q[lpr_pkg::CST_LSB +: 3];
   // Pin enables are ordered level 3, 2, 1 from the top bit down.
   assign pin_enable_d = {ladder_q[lpr_pkg::PE3_BIT], ladder_q[lpr_pkg::PE2_BIT],
      ladder_q[lpr_pkg::PE1_BIT]};
   assign power_a = lpr_pkg::lpr_pwr_t'(ladder_q[lpr_pkg::APWR_LSB +: 2]);
   assign power_b = lpr_pkg::lpr_pwr_t'(ladder_q[lpr_pkg::BPWR_LSB +: 2]);

   // Type B spans a whole frame of 32 counts, type A a common period of 16.
   assign period_last = waveform_type_select ? lpr_pkg::PERIOD_B_LAST : lpr_pkg::PERIOD_A_LAST;
   // Wrapping at or past the end keeps a type switch mid-period from stranding the counter.
   assign period_end = (sched_cnt_q >= period_last);
   // Interval A covers counts 0 to N-1; a zero code never enters it.
   assign in_a = (sched_cnt_q < {2'b00, a_len});
   // Interval and power are chosen together so the two outputs never disagree.
   assign interval_d = in_a ? lpr_pkg::LPR_IVL_A : lpr_pkg::LPR_IVL_B;
   assign power_d = in_a ? power_a : power_b;

   // Status word: failure flag and the live write-allow level, all other bits zero.
   always_comb
   begin
      status_word = 16'h0000;
      status_word[lpr_pkg::WFAIL_BIT] = wfail_q;
      status_word[lpr_pkg::WALLOW_BIT] = data_write_allowed;
   end

   // Pixel memory: 32 words, one bit per segment of one common.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < lpr_pkg::NUM_DATA_REGS; i++)
         begin
            pixel_on_data_x[i] <= lpr_pkg::DATA_RESET;
         end
      end
      else if (clk_en && pixel_we)
      begin
         pixel_on_data_x[reg_addr[4:0]] <= reg_wdata;
      end
   end

   // Ladder control register; unimplemented bits are never stored.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ladder_q <= lpr_pkg::LADDER_RESET;
      end
      else if (clk_en && ladder_we)
      begin
         ladder_q <= reg_wdata & lpr_pkg::LADDER_WMASK;
      end
   end

   // Next failure flag; a new refusal wins over a clear in the same cycle,
   // so a failure can never be lost to a clear that software issued too late.
   always_comb
   begin
      wfail_d = wfail_q;
      if (write_refused)
      begin
         wfail_d = 1'b1;
      end
      else if (status_clear)
      begin
         wfail_d = 1'b0;
      end
   end

   // Sticky write failure, held until software clears it.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wfail_q <= 1'b0;
      end
      else if (clk_en)
      begin
         wfail_q <= wfail_d;
      end
   end

   // Next schedule count; it moves only on an LCD clock tick.
   // The counter never stops, so the schedule runs even with a zero length code.
   always_comb
   begin
      sched_cnt_d = sched_cnt_q;
      if (lcd_tick)
      begin
         if (period_end)
         begin
            sched_cnt_d = 5'h00;
         end
         else
         begin
            sched_cnt_d = sched_cnt_q + 5'h01;
         end
      end
   end

   // Schedule counter, restarted at the end of every period.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sched_cnt_q <= 5'h00;
      end
      else if (clk_en)
      begin
         sched_cnt_q <= sched_cnt_d;
      end
   end

   // Read mux; unmapped words read as zero.
   always_comb
   begin
      rdata_d = 16'h0000;
      if (data_hit)
      begin
         rdata_d = pixel_on_data_x[reg_addr[4:0]];
      end
      else if (reg_addr == lpr_pkg::ADDR_LADDER)
      begin
         rdata_d = ladder_q;
      end
      else if (reg_addr == lpr_pkg::ADDR_STATUS)
      begin
         rdata_d = status_word;
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= 16'h0000;
      end
      else if (clk_en)
      begin
         reg_rdata <= reg_rd ? rdata_d : 16'h0000;
      end
   end

   // Gather the row of the selected common: register 4c+k holds segments 16k..16k+15.
   always_comb
   begin
      row_d = '0;
      for (int s = 0; s < NSEG; s++)
      begin
         row_d[s] = pixel_on_data_x[{common_select, 2'b00} + 5'(s / 16)][s % 16];
      end
   end

   // Registered pixel drive for the glass driver.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         segment_common_pixel_bit <= '0;
      end
      else if (clk_en)
      begin
         segment_common_pixel_bit <= row_d;
      end
   end

   // Internal reference enable; the analog side powers the reference from this bit alone.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ref_enable_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ref_enable_q <= ref_enable_d;
      end
   end

   // Contrast code; zero shorts the ladder, so the reset value gives full contrast.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         contrast_q <= 3'h0;
      end
      else if (clk_en)
      begin
         contrast_q <= contrast_d;
      end
   end

   // Bias pin routing; a clear bit keeps that level on the internal ladder.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_enable_q <= 3'h0;
      end
      else if (clk_en)
      begin
         pin_enable_q <= pin_enable_d;
      end
   end

   // Interval and ladder power; both lag the schedule counter by one cycle.
   // Registering them together avoids a glitch where power and interval disagree.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         interval_q <= lpr_pkg::LPR_IVL_A;
         power_q <= lpr_pkg::LPR_PWR_OFF;
      end
      else if (clk_en)
      begin
         interval_q <= interval_d;
         power_q <= power_d;
      end
   end

   // Failure flag copy for the pin; it trails the sticky flag by one cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         data_write_failed_flag <= 1'b0;
      end
      else if (clk_en)
      begin
         data_write_failed_flag <= wfail_q;
      end
   end

   // Gather the registered controls into the bundle for the bias generator.
   always_comb
   begin
      analog_ctrl.ref_enable = ref_enable_q;
      analog_ctrl.contrast = contrast_q;
      analog_ctrl.bias_pin_enable = pin_enable_q;
      analog_ctrl.power = power_q;
      analog_ctrl.interval = interval_q;
   end

endmodule

// *** logic/lpr_pkg.sv ***
package lpr_pkg;

   // Register word indices on the plain register port.
   localparam logic [5:0] ADDR_DATA_BASE = 6'h00;
   localparam logic [5:0] ADDR_LADDER = 6'h20;
   localparam logic [5:0] ADDR_STATUS = 6'h21;
   localparam int NUM_DATA_REGS = 32;
   localparam int DATA_W = 16;

   // Reference ladder control field positions.
   localparam int IRE_BIT = 15;
   localparam int CST_LSB = 11;
   localparam int PE3_BIT = 10;
   localparam int PE2_BIT = 9;
   localparam int PE1_BIT = 8;
   localparam int APWR_LSB = 6;
   localparam int BPWR_LSB = 4;
   localparam int ALEN_LSB = 0;
   localparam logic [15:0] LADDER_WMASK = 16'hbff7;
   localparam logic [15:0] LADDER_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;

   // Status register field positions.
   localparam int WFAIL_BIT = 5;
   localparam int WALLOW_BIT = 4;

   // Last count of each period in LCD clocks for the two waveform types.
   localparam logic [4:0] PERIOD_A_LAST = 5'h0f;
   localparam logic [4:0] PERIOD_B_LAST = 5'h1f;

   // Ladder power encodings.
   typedef enum logic [1:0]
   {
      LPR_PWR_OFF = 2'b00,
      LPR_PWR_LOW = 2'b01,
      LPR_PWR_MED = 2'b10,
      LPR_PWR_HIGH = 2'b11
   } lpr_pwr_t;

   // Interval phase of the ladder schedule.
   typedef enum logic [0:0]
   {
      LPR_IVL_A = 1'b0,
      LPR_IVL_B = 1'b1
   } lpr_ivl_t;

   // Analog control bundle toward the bias generator.
   typedef struct packed
   {
      logic ref_enable;
      logic [2:0] contrast;
      logic [2:0] bias_pin_enable;
      lpr_pwr_t power;
      lpr_ivl_t interval;
   } lpr_analog_t;

endpackage

// *** sim/lpr_glass_model.sv ***
`timescale 1ns/1ns
module lpr_glass_model (
   // Pixel row driven onto the glass.
   input wire logic [63:0] seg_row,
   // Pixels seen lit.
   output logic [6:0] lit_count
);
   // Optics are reduced to a count, since the glass has no timing of its own.
   assign lit_count = 7'($countones(seg_row));
endmodule

// *** sim/lpr_checker.sv ***
`timescale 1ns/1ns
module lpr_checker (
   // Clock, reset and register port.
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Status and outputs.
   input wire logic data_write_allowed,
   input wire lpr_pkg::lpr_analog_t analog_ctrl,
   input wire logic data_write_failed_flag
);
   logic [15:0] lad_q;
   wire rl = reg_rd && reg_addr == 6'h20;
   wire clr = reg_wr && reg_addr == 6'h21;
   // Shadow ladder word; assumes the clock enable stays high.
   always_ff @(posedge clk)
      lad_q <= rst ? 16'h0000 : (reg_wr && reg_addr == 6'h20) ? reg_wdata & 16'hbff7 : lad_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Outputs lag the word, so it must hold still first.
   sequence s_still;
      !$past(rst) ##0 $stable(lad_q)[*2];
   endsequence
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("idle");
   chk_ladder_read: assert property (rl |=> reg_rdata == $past(lad_q)) else $error("ladder");
   chk_rsvd_zero: assert property (rl |=> (reg_rdata & 16'h4008) == 16'h0000) else $error("rsvd");
   chk_ctrl_fields: assert property (s_still |-> analog_ctrl[9:3] == {lad_q[15], lad_q[13:8]})
      else $error("ctrl");
   chk_power_pick: assert property (s_still |-> analog_ctrl[2:1] == (analog_ctrl[0] ? lad_q[5:4] : lad_q[7:6]))
      else $error("power");
   chk_len_zero: assert property (s_still ##0 lad_q[2:0] == 3'h0 |-> analog_ctrl[0]) else $error("len");
   chk_fail_set: assert property (reg_wr && reg_addr < 6'h20 && !data_write_allowed
      |=> ##1 data_write_failed_flag) else $error("set");
   chk_fail_hold: assert property (data_write_failed_flag && !clr && !$past(clr)
      |=> data_write_failed_flag) else $error("hold");
endmodule

// *** sim/lcd_pixel_data_and_ref_ladder_tb.sv ***
`timescale 1ns/1ns
module lcd_pixel_data_and_ref_ladder_tb;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ok = 1'b1, wave_b = 1'b0, fl;
   logic [5:0] a = 6'h00;
   logic [15:0] d = 16'h0000, q, rv, lad, mem [32];
   logic [2:0] com = 3'h0;
   logic [63:0] row, ex;
   logic [6:0] lit;
   lpr_pkg::lpr_analog_t ac;
   int n_fail = 0, cmp_count = 0, na;
   // Enable and tick held high, so the schedule steps every cycle.
   lpr_top lpr_top_inst (.clk(clk), .rst(rst), .clk_en(1'b1), .reg_addr(a), .reg_wdata(d), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(q), .data_write_allowed(ok), .waveform_type_select(wave_b), .lcd_tick(1'b1), .common_select(com),
      .segment_common_pixel_bit(row), .analog_ctrl(ac), .data_write_failed_flag(fl));
   lpr_glass_model lpr_glass_model_inst (.seg_row(row), .lit_count(lit));
   // Clock and watchdog.
   initial forever #50 clk = ~clk;
   initial #1000000 end_of_test(1);
   // Case equality, so an unknown never matches a known value.
   task automatic chk(logic [63:0] s, logic [63:0] e);
      cmp_count++;
      n_fail += int'(s !== e);
      if (s !== e)
         $display("[ERR] %0t seen %h want %h", $time, s, e);
   endtask
   // One bus cycle; read data are taken just after the next edge.
   task automatic bus(logic w, logic [5:0] ad, logic [15:0] wd);
      wr <= w;
      rd <= !w;
      a <= ad;
      d <= wd;
      @(posedge clk);
      #1 rv = q;
   endtask
   // Reads of an unmapped word serve as idle cycles.
   task automatic idle(int n);
      repeat (n) bus(1'b0, 6'h3f, 16'h0000);
   endtask
   task automatic end_of_test(int extra);
      n_fail += extra;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Main sequence.
   initial
   begin
      void'($urandom(58));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      chk(rv, 16'h0000);
      for (int x = 0; x < 32; x++)
      begin
         mem[x] = x == 0 ? 16'hffff : 16'($urandom);
         bus(1'b1, 6'(x), mem[x]);
      end
      for (int c = 0; c < 8; c++)
      begin
         com <= 3'(c);
         ex = {mem[4 * c + 3], mem[4 * c + 2], mem[4 * c + 1], mem[4 * c]};
         idle(2);
         chk(row, ex);
         chk(lit, $countones(ex));
      end
      ok <= 1'b0;
      bus(1'b1, 6'h05, ~mem[5]);
      ok <= 1'b1;
      bus(1'b0, 6'h05, 16'h0000);
      chk(rv, mem[5]);
      chk(fl, 1'b1);
      bus(1'b0, 6'h21, 16'h0000);
      chk(rv, 16'h0030);
      bus(1'b1, 6'h21, 16'h0000);
      idle(2);
      chk(fl, 1'b0);
      for (int k = 0; k < 16; k++)
      begin
         lad = {1'(k), 1'b1, 6'($urandom), 4'($urandom), 1'b1, 3'(k)};
         wave_b <= k[3];
         bus(1'b1, 6'h20, lad);
         bus(1'b0, 6'h20, 16'h0000);
         chk(rv, lad & 16'hbff7);
         idle(40);
         chk(ac[9:3], {lad[15], lad[13:8]});
         na = 0;
         repeat (64)
         begin
            na += int'(ac.interval === lpr_pkg::LPR_IVL_A);
            chk(ac.power, ac.interval ? lad[5:4] : lad[7:6]);
            idle(1);
         end
         chk(na, k % 8 * (k > 7 ? 2 : 4));
      end
      end_of_test(0);
   end
endmodule
bind lpr_top lpr_checker lpr_checker_inst (.*);
